// ---- design/wmg_pkg.sv ----
// package: register map, field positions, reset values and sizes of the marker generator
package wmg_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned POINT_W = 18;
  localparam int unsigned SEG_AW = 10;
  localparam int unsigned SEG_DEPTH = 1024;
  localparam int unsigned SEQ_DEPTH = 4;
  localparam int unsigned NUM_MARKERS = 4;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FIRST = 8'h04;
  localparam logic [7:0] OFS_LAST = 8'h08;
  localparam logic [7:0] OFS_SKIP = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_CUSTOM = 8'h14;
  localparam logic [7:0] OFS_SEQ = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // control field positions
  localparam int unsigned CTRL_ARB_ON = 0;
  localparam int unsigned CTRL_RF_BLANK = 1;
  localparam int unsigned CTRL_MARK_SEL = 2;
  localparam int unsigned CTRL_SEQ_MODE = 3;
  localparam int unsigned CTRL_TRIG_MODE = 4;
  localparam int unsigned CTRL_TRIG_SRC = 6;
  localparam int unsigned CTRL_SEQ_LAST = 8;
  localparam int unsigned CTRL_SEG_LAST = 10;
  localparam logic [31:0] CTRL_RESET = 32'h000FFC00;
  // command bits
  localparam int unsigned CMD_PLACE_FIRST = 0;
  localparam int unsigned CMD_PLACE_RANGE = 1;
  localparam int unsigned CMD_SW_TRIG = 3;
  // custom marker word, sequence entry and status word fields
  localparam int unsigned CUSTOM_MARK = 16;
  localparam int unsigned SEQ_EN = 2;
  localparam int unsigned SEQ_INSERT = 4;
  localparam int unsigned STAT_ENTRY = 2;
  localparam int unsigned STAT_ADDR = 12;
  localparam int unsigned STAT_CODE = 24;
  // marker status column codes
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_ONE = 8'h01;
  localparam logic [7:0] CODE_TWO = 8'h02;
  localparam logic [7:0] CODE_BOTH = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TRIG_CONT = 2'h0, TRIG_SINGLE = 2'h1, TRIG_GATED = 2'h2, TRIG_SEGADV = 2'h3
  } wmg_trig_t;
  typedef enum logic [1:0] {
    SRC_KEY = 2'h0, SRC_REMOTE = 2'h1, SRC_EXT = 2'h2
  } wmg_src_t;
  typedef enum logic [1:0] {PL_IDLE = 2'b01, PL_RUN = 2'b10} wmg_place_t;
endpackage : wmg_pkg

// ---- design/wmg_marker_gen.sv ----
// module: per-sample marker generator with sequence gating, rf blanking and AXI4-Lite registers
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module wmg_marker_gen
  import wmg_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trigger inputs from pins
  input wire logic trigKeyIn,
  input wire logic extTrigIn,
  // sample stream
  input wire logic sampleValid,
  input wire logic [DATA_W-1:0] sampleData,
  output logic sampleOutValid,
  output logic [DATA_W-1:0] sampleOut,
  // marker and blanking outputs
  output logic event1Out,
  output logic event2Out,
  output logic aux3Out,
  output logic aux4Out,
  output logic rfBlankOut
);
  function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : strbMerge

  function automatic logic [7:0] colCode(input logic e1, input logic e2);
    return (e1 && e2) ? CODE_BOTH : e1 ? CODE_ONE : e2 ? CODE_TWO : CODE_NONE;
  endfunction : colCode

  logic [NUM_MARKERS-1:0] segMem [SEG_DEPTH];
  logic [31:0] ctrl_ff, firstPt_ff, lastPt_ff, skip_ff;
  logic [SEQ_DEPTH-1:0] en1_ff, en2_ff;
  logic [1:0] lastState_ff, seqSel_ff;
  logic awPend_ff, wPend_ff, awRdy_ff, wRdy_ff, bValid_ff, arRdy_ff, rValid_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [31:0] wData_ff, rData_ff;
  logic [3:0] wStrb_ff;
  logic [1:0] bResp_ff, rResp_ff;
  wmg_place_t place_ff;
  logic [POINT_W-1:0] cur_ff;
  logic [31:0] skipCnt_ff;
  logic [2:0] keySync_ff, extSync_ff;
  logic playing_ff;
  logic [1:0] entry_ff;
  logic [SEG_AW-1:0] addr_ff;
  logic outValid_ff, ev1_ff, ev2_ff, aux3_ff, aux4_ff, blank_ff;
  logic [DATA_W-1:0] outData_ff;

  // write channel: address and data are taken in either order
  wire awTake = s_axi_awvalid && awRdy_ff;
  wire wTake = s_axi_wvalid && wRdy_ff;
  wire doWrite = awPend_ff && wPend_ff && !bValid_ff;
  wire nxt_awPend = (awPend_ff || awTake) && !doWrite;
  wire nxt_wPend = (wPend_ff || wTake) && !doWrite;
  wire nxt_bValid = doWrite || (bValid_ff && !s_axi_bready);
  wire [ADDR_W-1:0] wA = awAddr_ff;
  wire wrCtrl = doWrite && wA == OFS_CTRL;
  wire wrFirst = doWrite && wA == OFS_FIRST;
  wire wrLast = doWrite && wA == OFS_LAST;
  wire wrSkip = doWrite && wA == OFS_SKIP;
  wire wrCmd = doWrite && wA == OFS_CMD;
  wire wrCustom = doWrite && wA == OFS_CUSTOM;
  wire wrSeq = doWrite && wA == OFS_SEQ;
  wire wrOk = wrCtrl || wrFirst || wrLast || wrSkip || wrCmd || wrCustom || wrSeq;
  wire [31:0] cmdVal = strbMerge(32'h00000000, wData_ff, wStrb_ff);
  wire [31:0] seqVal = strbMerge(32'h00000000, wData_ff, wStrb_ff);

  // control fields
  wire arbOn = ctrl_ff[CTRL_ARB_ON];
  wire rfBlankEn = ctrl_ff[CTRL_RF_BLANK];
  wire markSel = ctrl_ff[CTRL_MARK_SEL];
  wire seqMode = ctrl_ff[CTRL_SEQ_MODE];
  wire [1:0] trigMode = ctrl_ff[CTRL_TRIG_MODE +: 2];
  wire [1:0] trigSrc = ctrl_ff[CTRL_TRIG_SRC +: 2];
  wire [1:0] seqLast = ctrl_ff[CTRL_SEQ_LAST +: 2];
  wire [SEG_AW-1:0] segLast = ctrl_ff[CTRL_SEG_LAST +: SEG_AW];

  // trigger selection; key and external pins pass two flops first
  wire keyRise = keySync_ff[1] && !keySync_ff[2];
  wire extRise = extSync_ff[1] && !extSync_ff[2];
  wire swTrig = wrCmd && cmdVal[CMD_SW_TRIG];
  wire trigPulse = (trigSrc == SRC_KEY) ? keyRise :
                   (trigSrc == SRC_REMOTE) ? swTrig : extRise;
  wire gateLevel = (trigSrc == SRC_KEY) ? keySync_ff[1] : extSync_ff[1];
  // gated mode pauses the read pointer instead of restarting the segment
  wire runNow = arbOn && (trigMode == TRIG_GATED ? gateLevel : playing_ff);
  wire step = sampleValid && runNow;
  wire segEnd = addr_ff == segLast || addr_ff == SEG_AW'(SEG_DEPTH - 1);
  wire seqEnd = !seqMode || entry_ff == seqLast;

  // placement engine: one sample per cycle, marker bit or-ed in
  wire startFirst = wrCmd && cmdVal[CMD_PLACE_FIRST] && place_ff == PL_IDLE;
  wire startRange = wrCmd && cmdVal[CMD_PLACE_RANGE] && place_ff == PL_IDLE &&
                    !cmdVal[CMD_PLACE_FIRST];
  wire markHit = place_ff == PL_RUN && skipCnt_ff == 32'h00000000;
  wire rangeDone = cur_ff == lastPt_ff[POINT_W-1:0] || cur_ff >= POINT_W'(SEG_DEPTH - 1);
  wire [NUM_MARKERS-1:0] selMask = markSel ? 4'h2 : 4'h1;
  wire [NUM_MARKERS-1:0] rawMarks = segMem[addr_ff];
  wire gate1 = !seqMode || en1_ff[entry_ff];
  wire gate2 = !seqMode || en2_ff[entry_ff];
  wire [7:0] curCode = colCode(en1_ff[seqSel_ff], en2_ff[seqSel_ff]);
  wire [31:0] statusVal = {colCode(en1_ff[entry_ff], en2_ff[entry_ff]), 2'h0,
                           addr_ff, 8'h00, entry_ff, playing_ff, place_ff == PL_RUN};
  wire [31:0] seqRd = {16'h0000, curCode, 3'h0, en2_ff[seqSel_ff], en1_ff[seqSel_ff], 1'b0,
                       seqSel_ff};
  wire [ADDR_W-1:0] rA = s_axi_araddr;
  wire rdHit = rA == OFS_CTRL || rA == OFS_FIRST || rA == OFS_LAST || rA == OFS_SKIP ||
               rA == OFS_CMD || rA == OFS_CUSTOM || rA == OFS_SEQ || rA == OFS_STATUS;
  wire [31:0] rdMux = rA == OFS_CTRL ? ctrl_ff : rA == OFS_FIRST ? firstPt_ff :
                      rA == OFS_LAST ? lastPt_ff : rA == OFS_SKIP ? skip_ff :
                      rA == OFS_SEQ ? seqRd : rA == OFS_STATUS ? statusVal : 32'h00000000;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      awPend_ff <= 1'b0;
      wPend_ff <= 1'b0;
      awRdy_ff <= 1'b0;
      wRdy_ff <= 1'b0;
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
    end else begin
      awPend_ff <= nxt_awPend;
      wPend_ff <= nxt_wPend;
      awRdy_ff <= !nxt_awPend && !nxt_bValid;
      wRdy_ff <= !nxt_wPend && !nxt_bValid;
      bValid_ff <= nxt_bValid;
      if (doWrite) bResp_ff <= wrOk ? RESP_OKAY : RESP_SLVERR;
      if (awTake) awAddr_ff <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      if (wTake) wData_ff <= s_axi_wdata;
      if (wTake) wStrb_ff <= s_axi_wstrb;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      arRdy_ff <= 1'b0;
      rValid_ff <= 1'b0;
      rData_ff <= 32'h00000000;
      rResp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && arRdy_ff) begin
      arRdy_ff <= 1'b0;
      rValid_ff <= 1'b1;
      rData_ff <= rdMux;
      rResp_ff <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_ff && s_axi_rready) begin
      rValid_ff <= 1'b0;
      arRdy_ff <= 1'b1;
    end else if (!rValid_ff) begin
      arRdy_ff <= 1'b1;
    end
  end

  // configuration and sequence table
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= CTRL_RESET;
      firstPt_ff <= 32'h00000000;
      lastPt_ff <= 32'h00000000;
      skip_ff <= 32'h00000000;
      en1_ff <= 4'h0;
      en2_ff <= 4'h0;
      lastState_ff <= 2'h0;
      seqSel_ff <= 2'h0;
    end else begin
      if (wrCtrl) ctrl_ff <= strbMerge(ctrl_ff, wData_ff, wStrb_ff);
      if (wrFirst) firstPt_ff <= strbMerge(firstPt_ff, wData_ff, wStrb_ff);
      if (wrLast) lastPt_ff <= strbMerge(lastPt_ff, wData_ff, wStrb_ff);
      if (wrSkip) skip_ff <= strbMerge(skip_ff, wData_ff, wStrb_ff);
      if (wrSeq) begin
        seqSel_ff <= seqVal[1:0];
        if (seqVal[SEQ_INSERT]) begin
          en1_ff[seqVal[1:0]] <= lastState_ff[0];
          en2_ff[seqVal[1:0]] <= lastState_ff[1];
        end else begin
          en1_ff[seqVal[1:0]] <= seqVal[SEQ_EN];
          en2_ff[seqVal[1:0]] <= seqVal[SEQ_EN+1];
          lastState_ff <= seqVal[SEQ_EN +: 2];
        end
      end
    end
  end

  // placement engine; software keeps last >= first, otherwise it stops at memory point SEG_DEPTH - 1, not at segLast
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      place_ff <= PL_IDLE;
      cur_ff <= 18'h00000;
      skipCnt_ff <= 32'h00000000;
    end else begin
      case (place_ff)
        PL_IDLE: begin
          if (startRange) begin
            place_ff <= PL_RUN;
            cur_ff <= firstPt_ff[POINT_W-1:0];
            skipCnt_ff <= 32'h00000000;
          end
        end
        PL_RUN: begin
          skipCnt_ff <= markHit ? skip_ff : skipCnt_ff - 32'h00000001;
          if (rangeDone) place_ff <= PL_IDLE;
          else cur_ff <= cur_ff + 18'h00001;
        end
        default: place_ff <= PL_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (startFirst) begin
      segMem[0] <= segMem[0] | selMask;
    end else if (markHit) begin
      segMem[cur_ff[SEG_AW-1:0]] <= segMem[cur_ff[SEG_AW-1:0]] | selMask;
    end else if (wrCustom) begin
      segMem[wData_ff[SEG_AW-1:0]] <= wData_ff[CUSTOM_MARK +: NUM_MARKERS];
    end
  end

  // playback pointer and trigger handling
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      keySync_ff <= 3'h0;
      extSync_ff <= 3'h0;
      playing_ff <= 1'b0;
      entry_ff <= 2'h0;
      addr_ff <= 10'h000;
    end else begin
      keySync_ff <= {keySync_ff[1:0], trigKeyIn};
      extSync_ff <= {extSync_ff[1:0], extTrigIn};
      if (!arbOn) begin
        playing_ff <= 1'b0;
        entry_ff <= 2'h0;
        addr_ff <= 10'h000;
      end else if (trigMode == TRIG_SEGADV && playing_ff && trigPulse) begin
        entry_ff <= seqEnd ? 2'h0 : entry_ff + 2'h1;
        addr_ff <= 10'h000;
      end else begin
        if (trigMode == TRIG_CONT || trigMode == TRIG_SEGADV) playing_ff <= 1'b1;
        else if (trigMode == TRIG_SINGLE && trigPulse) playing_ff <= 1'b1;
        if (step) begin
          addr_ff <= segEnd ? 10'h000 : addr_ff + 10'h001;
          if (segEnd && trigMode != TRIG_SEGADV) begin
            entry_ff <= seqEnd ? 2'h0 : entry_ff + 2'h1;
            if (seqEnd && trigMode == TRIG_SINGLE) playing_ff <= 1'b0;
          end
        end
      end
    end
  end

  // sample and markers leave in the same cycle, one register after the input
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      outValid_ff <= 1'b0;
      outData_ff <= 32'h00000000;
      ev1_ff <= 1'b0;
      ev2_ff <= 1'b0;
      aux3_ff <= 1'b0;
      aux4_ff <= 1'b0;
      blank_ff <= 1'b0;
    end else begin
      outValid_ff <= step;
      if (step) outData_ff <= sampleData;
      ev1_ff <= step && rawMarks[0] && gate1;
      ev2_ff <= step && rawMarks[1] && gate2;
      aux3_ff <= step && rawMarks[2];
      aux4_ff <= step && rawMarks[3];
      blank_ff <= step && rfBlankEn && rawMarks[1] && gate2;
    end
  end

  assign s_axi_awready = awRdy_ff;
  assign s_axi_wready = wRdy_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = arRdy_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;
  assign sampleOutValid = outValid_ff;
  assign sampleOut = outData_ff;
  assign event1Out = ev1_ff;
  assign event2Out = ev2_ff;
  assign aux3Out = aux3_ff;
  assign aux4Out = aux4_ff;
  assign rfBlankOut = blank_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_first_point;
    startFirst && !markSel |=> segMem[0][0];
  endproperty
  a_first_point: assert property (p_first_point) else $error("first point not marked");
  property p_range_run;
    startRange |=> place_ff == PL_RUN && cur_ff == firstPt_ff[POINT_W-1:0];
  endproperty
  a_range_run: assert property (p_range_run) else $error("range did not start");
  property p_skip_spacing;
    markHit && !rangeDone && skip_ff == 32'h00000002 && !wrSkip
      |=> !markHit ##1 !markHit;
  endproperty
  a_skip_spacing: assert property (p_skip_spacing) else $error("skip spacing wrong");
  property p_blank_src;
    rfBlankOut |-> event2Out && $past(rfBlankEn);
  endproperty
  a_blank_src: assert property (p_blank_src) else $error("blank without marker two");
  property p_seq_gate;
    step && seqMode && !en1_ff[entry_ff] |=> !event1Out;
  endproperty
  a_seq_gate: assert property (p_seq_gate) else $error("disabled marker leaked");
  property p_insert;
    wrSeq && seqVal[SEQ_INSERT] |=> {en2_ff[seqSel_ff], en1_ff[seqSel_ff]}
      == $past(lastState_ff);
  endproperty
  a_insert: assert property (p_insert) else $error("insert state wrong");
  property p_code;
    (curCode == CODE_NONE) == (!en1_ff[seqSel_ff] && !en2_ff[seqSel_ff]);
  endproperty
  a_code: assert property (p_code) else $error("bad status code");
  property p_align;
    step |=> sampleOutValid && sampleOut == $past(sampleData);
  endproperty
  a_align: assert property (p_align) else $error("sample not aligned");
  property p_write_resp;
    doWrite |=> s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("no write response");
  c_range: cover property (startRange ##[1:20] place_ff == PL_IDLE);
  c_blank: cover property (rfBlankOut);
  c_segadv: cover property (trigMode == TRIG_SEGADV && trigPulse && playing_ff);
endmodule : wmg_marker_gen
`default_nettype wire

// ---- test/wmg_scope_model.sv ----
// scope model: counts the cycles in which each event output is high
`timescale 1ns/100ps
`default_nettype none
module wmg_scope_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // event outputs of the generator
  input wire logic event1Out,
  input wire logic event2Out,
  // totals of high cycles
  output var int highCount1,
  output var int highCount2
);
  // only a high level counts, so an inverted output shows up as a wrong total
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      highCount1 <= 0;
      highCount2 <= 0;
    end else begin
      highCount1 <= highCount1 + int'(event1Out === 1'b1);
      highCount2 <= highCount2 + int'(event2Out === 1'b1);
    end
  end
endmodule : wmg_scope_model
`default_nettype wire

// ---- test/wmg_marker_gen_tb_top.sv ----
// testbench: random and corner stimulus for the marker generator
`timescale 1ns/100ps
`default_nettype none
module wmg_marker_gen_tb_top
  import wmg_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic trigKeyIn = 1'b0;
  logic extTrigIn = 1'b0;
  logic sampleValid = 1'b0;
  logic [DATA_W-1:0] sampleData = '0;
  logic sampleOutValid, event1Out, event2Out, aux3Out, aux4Out, rfBlankOut;
  logic [DATA_W-1:0] sampleOut;
  int highCount1, highCount2;
  int failures = 0, tests_run = 0, cycles = 0, expHigh1 = 0, expHigh2 = 0;
  integer seed = 32'hAB234F90;
  logic [3:0] mem [8];
  logic [31:0] sent [8];
  logic rfOn = 1'b0, seqOn = 1'b0, en1 = 1'b1, en2 = 1'b1, playExp = 1'b1;
  logic [1:0] resp;
  logic [31:0] rd;
  int firstT [3] = '{3, 1, 2};
  int lastT [3] = '{3, 7, 6}; // never below firstT
  int skipT [3] = '{0, 2, 1};
  logic selT [3] = '{1'b1, 1'b1, 1'b0};
  logic [7:0] codeT [4] = '{CODE_NONE, CODE_ONE, CODE_TWO, CODE_BOTH};

  wmg_marker_gen i_dut (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .trigKeyIn, .extTrigIn, .sampleValid, .sampleData,
    .sampleOutValid, .sampleOut, .event1Out, .event2Out, .aux3Out, .aux4Out, .rfBlankOut);
  wmg_scope_model i_scope (.core_clk, .nrst, .event1Out, .event2Out, .highCount1, .highCount2);

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic results();
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // tasks start just after an edge and end one edge after releasing
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    logic awOk, wOk;
    awOk = 1'b0;
    wOk = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(awOk && wOk)) begin
      @(posedge core_clk);
      if (!awOk && s_axi_awready === 1'b1) begin
        awOk = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wOk && s_axi_wready === 1'b1) begin
        wOk = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask : axiRead

  function automatic logic [4:0] expOut(input logic [3:0] m);
    logic g1, g2;
    g1 = m[0] & (en1 | !seqOn);
    g2 = m[1] & (en2 | !seqOn);
    return {rfOn & g2, m[3], m[2], g2, g1};
  endfunction : expOut

  // segment last sample 7, continuous trigger, player on
  task automatic setCtrl(input logic sel);
    axiWrite(OFS_CTRL, 32'h00001C01 | {28'h0, seqOn, sel, rfOn, 1'b0});
  endtask : setCtrl

  // player off first, so pointer, entry and run state start afresh; two entries of 8 samples
  task automatic setRun(input logic [1:0] mode, input logic [1:0] src);
    axiWrite(OFS_CTRL, 32'h00001C00);
    axiWrite(OFS_CTRL, 32'h00001D01 | {24'h0, src, mode, seqOn, 1'b0, rfOn, 1'b0});
  endtask : setRun

  // eight back-to-back samples, one full pass of the segment
  task automatic stream();
    logic [4:0] e;
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      if (i >= 2) begin
        e = playExp ? expOut(mem[i-2]) : 5'h00;
        expHigh1 += int'(e[0]);
        expHigh2 += int'(e[1]);
        check({31'h0, sampleOutValid}, {31'h0, playExp});
        if (playExp) check(sampleOut, sent[i-2]);
        check({30'h0, event2Out, event1Out}, {30'h0, e[1:0]});
        check({30'h0, aux4Out, aux3Out}, {30'h0, e[3:2]});
        check({31'h0, rfBlankOut}, {31'h0, e[4]});
      end
      if (i < 8) begin
        sent[i] = $random(seed);
        sampleData <= sent[i];
      end
      sampleValid <= (i < 8);
    end
  endtask : stream

  task automatic place(input logic [31:0] cmd, input logic sel);
    setCtrl(sel);
    axiWrite(OFS_CMD, cmd);
    rd = 32'h1;
    for (int n = 0; n < 64 && rd[0] !== 1'b0; n++) axiRead(OFS_STATUS);
    check({31'h0, rd[0]}, 32'h0);
  endtask : place

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    axiRead(OFS_CTRL);
    check(rd, CTRL_RESET);
    axiRead(8'h40);
    check({rd[29:0], resp}, {30'h0, RESP_SLVERR});
    axiWrite(OFS_STATUS, 32'hFFFFFFFF);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 8; i++) begin
      mem[i] = 4'($random(seed));
      axiWrite(OFS_CUSTOM, {12'h0, mem[i], 6'h0, 10'(i)});
      check({30'h0, resp}, {30'h0, RESP_OKAY});
    end
    setCtrl(1'b0);
    stream();
    rfOn = 1'b1;
    setCtrl(1'b0);
    stream();
    for (int i = 0; i < 8; i++) begin
      mem[i] = 4'h0;
      axiWrite(OFS_CUSTOM, {22'h0, 10'(i)});
    end
    place(32'h1, 1'b0);
    mem[0][0] = 1'b1;
    stream();
    // placement ORs into the stored bits, so the model accumulates too
    for (int k = 0; k < 3; k++) begin
      axiWrite(OFS_FIRST, 32'(firstT[k]));
      axiWrite(OFS_LAST, 32'(lastT[k]));
      axiWrite(OFS_SKIP, 32'(skipT[k]));
      for (int p = firstT[k]; p <= lastT[k]; p += skipT[k] + 1) mem[p][selT[k]] = 1'b1;
      place(32'h2, selT[k]);
      stream();
    end
    seqOn = 1'b1;
    setCtrl(1'b0);
    for (int k = 0; k < 4; k++) begin
      {en2, en1} = 2'(k);
      axiWrite(OFS_SEQ, {28'h0, en2, en1, 2'h0});
      axiRead(OFS_SEQ);
      check({24'h0, rd[15:8]}, {24'h0, codeT[k]});
      stream();
    end
    axiWrite(OFS_SEQ, 32'h11);
    axiRead(OFS_SEQ);
    check({24'h0, rd[15:8]}, {24'h0, CODE_BOTH});
    // two entries with opposite enables; single play starts on a register trigger
    axiWrite(OFS_SEQ, 32'h00000008);
    axiWrite(OFS_SEQ, 32'h00000005);
    setRun(TRIG_SINGLE, SRC_REMOTE);
    playExp = 1'b0;
    stream();
    axiWrite(OFS_CMD, 32'h1 << CMD_SW_TRIG);
    playExp = 1'b1;
    {en2, en1} = 2'b10;
    stream();
    {en2, en1} = 2'b01;
    stream();
    // single play stops after the last entry's last sample
    playExp = 1'b0;
    stream();
    // gated by the external pin, which passes the synchroniser first
    setRun(TRIG_GATED, SRC_EXT);
    extTrigIn <= 1'b1;
    repeat (3) @(posedge core_clk);
    playExp = 1'b1;
    {en2, en1} = 2'b10;
    stream();
    extTrigIn <= 1'b0;
    repeat (3) @(posedge core_clk);
    playExp = 1'b0;
    stream();
    // segment advance: a key press jumps from entry zero to entry one
    setRun(TRIG_SEGADV, SRC_KEY);
    playExp = 1'b1;
    {en2, en1} = 2'b10;
    stream();
    trigKeyIn <= 1'b1;
    repeat (4) @(posedge core_clk);
    trigKeyIn <= 1'b0;
    {en2, en1} = 2'b01;
    stream();
    check(32'(highCount1), 32'(expHigh1));
    check(32'(highCount2), 32'(expHigh2));
    results();
  end
endmodule : wmg_marker_gen_tb_top
`default_nettype wire
